//--- aprf_top.sv
/*
  Control logic around a 10-bit converter: power state, reset effects,
  analog pin configuration, result buffer and result format.
  Assumes an APB master on pclk, a converter core that raises core_done
  with core_data after core_start, and port pins from outside the domain.
*/
// Implementation choices: the placing of the registers and the APB slave port.
// What this block does
// - Converter-on set: converter powered and able to convert.
// - Converter-on clear: state machine held idle, pending requests dropped.
// - Device reset clears the control register, turning converter off, aborting; analog-select and direction bits reset to all ones.
// - Device reset leaves result buffer contents untouched.
// - Result buffer holds undefined contents after power-on.
// - Analog-select clear: pin analog, digital input buffer disabled.
// - Analog-select set: converter input tied to analog ground.
// - Port read returns zero for every pin configured analog whose synchronised level has been steady for two samples.
// - Conversions run regardless of analog-select and direction bits.
// - Each conversion gives 10 bits stored in 16-bit buffer entries.
// - Format select picks one of two 16-bit result presentations.
`timescale 1ns/100ps
`default_nettype none

module aprf_top #(
  parameter int NPIN = 8,
  parameter int NBUF = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Analog port pins
  input  wire logic [NPIN-1:0]  pin_level,
  output logic      [NPIN-1:0]  pin_dig_in_en,
  output logic      [NPIN-1:0]  pin_to_analog_ground_ref,
  output logic      [NPIN-1:0]  pin_direction_out,
  // Converter core
  output logic                  core_power,
  output logic                  core_start,
  output logic      [2:0]       core_channel,
  input  wire logic             core_done,
  input  wire logic [9:0]       core_data
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  aprf_pkg::aprf_ctrl_t   ctrl_ff;
  aprf_pkg::aprf_state_t  state_ff;
  logic [NPIN-1:0]        pin_analog_select_ff;
  logic [NPIN-1:0]        pin_direction_ff;
  logic [NPIN-1:0]        sync1_ff;
  logic [NPIN-1:0]        sync2_ff;
  logic [NPIN-1:0]        sync3_ff;
  logic [NPIN-1:0]        port_ff;
  logic [NPIN-1:0]        pend_ff;
  logic [2:0]             chan_ff;
  logic [3:0]             cnt_ff;
  logic [15:0]            result_buffer [NBUF];
  logic                   done_seen_ff;
  logic                   wr_en;
  logic                   rd_en;
  logic                   req_wr;
  logic [31:0]            nxt_rdata;
  logic                   nxt_err;
  logic [2:0]             pick;
  logic                   any_pend;
  logic [9:0]             raw;
  logic [15:0]            fmt;
  logic [2:0]             buf_idx;
  logic                   buf_hit;

  assign wr_en   = psel & penable & pwrite & ~pready;
  assign rd_en   = psel & penable & ~pwrite & ~pready;
  assign req_wr  = wr_en & (paddr == aprf_pkg::OFS_REQ);
  assign buf_idx = paddr[4:2];
  assign buf_hit = (paddr[11:5] == aprf_pkg::OFS_BUF_BASE[11:5]) &&
                   (32'(buf_idx) < NBUF);

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff              <= '0;
      pin_analog_select_ff <= NPIN'(aprf_pkg::PINCFG_RST);
      pin_direction_ff     <= NPIN'(aprf_pkg::PINDIR_RST);
    end else if (wr_en) begin
      case (paddr)
        aprf_pkg::OFS_CTRL: begin
          ctrl_ff.converter_on         <= pwdata[aprf_pkg::CTRL_ON_BIT];
          ctrl_ff.result_format_select <= pwdata[aprf_pkg::CTRL_RESULT_FORMAT_SELECT_BIT];
        end
        aprf_pkg::OFS_PINCFG: begin
          pin_analog_select_ff <= pwdata[NPIN-1:0];
        end
        aprf_pkg::OFS_PINDIR: begin
          pin_direction_ff <= pwdata[NPIN-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pin input synchroniser and port value
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      port_ff  <= '0;
    end else begin
      sync1_ff <= pin_level;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      for (int i = 0; i < NPIN; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          port_ff[i] <= sync3_ff[i] & pin_analog_select_ff[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin controls
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_dig_in_en            <= '0;
      pin_to_analog_ground_ref <= '0;
      pin_direction_out        <= '0;
    end else begin
      pin_dig_in_en            <= pin_analog_select_ff;
      pin_to_analog_ground_ref <= pin_analog_select_ff;
      pin_direction_out        <= ~pin_direction_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion requests
  // ----------------------------------------------------------------------
  always_comb begin
    pick     = '0;
    any_pend = 1'b0;
    for (int i = NPIN - 1; i >= 0; i--) begin
      if (pend_ff[i]) begin
        pick     = 3'(i);
        any_pend = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= '0;
    end else if (!ctrl_ff.converter_on) begin
      pend_ff <= '0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (req_wr && pwdata[i]) begin
          pend_ff[i] <= 1'b1;
        end else if (state_ff == aprf_pkg::ST_IDLE && any_pend &&
                     32'(pick) == i) begin
          pend_ff[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= aprf_pkg::ST_IDLE;
      chan_ff      <= '0;
      cnt_ff       <= '0;
      done_seen_ff <= 1'b0;
    end else if (!ctrl_ff.converter_on) begin
      state_ff     <= aprf_pkg::ST_IDLE;
      cnt_ff       <= '0;
      done_seen_ff <= 1'b0;
    end else begin
      case (state_ff)
        aprf_pkg::ST_IDLE: begin
          done_seen_ff <= 1'b0;
          if (any_pend) begin
            chan_ff  <= pick;
            cnt_ff   <= aprf_pkg::CONV_CYCLES;
            state_ff <= aprf_pkg::ST_SAMP;
          end
        end
        aprf_pkg::ST_SAMP: begin
          state_ff <= aprf_pkg::ST_CONV;
        end
        aprf_pkg::ST_CONV: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end
          if (core_done) begin
            done_seen_ff <= 1'b1;
            state_ff     <= aprf_pkg::ST_IDLE;
          end else if (cnt_ff == '0) begin
            // Core never answered: give up so the queue cannot stall
            state_ff     <= aprf_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= aprf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_power   <= 1'b0;
      core_start   <= 1'b0;
      core_channel <= '0;
    end else begin
      core_power   <= ctrl_ff.converter_on;
      core_start   <= ctrl_ff.converter_on && state_ff == aprf_pkg::ST_SAMP;
      core_channel <= chan_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Result buffer, no reset so contents survive a device reset
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (ctrl_ff.converter_on && state_ff == aprf_pkg::ST_CONV && core_done) begin
      result_buffer[chan_ff] <= {6'h00, core_data};
    end
  end

  // ----------------------------------------------------------------------
  // Read path and result format
  // ----------------------------------------------------------------------
  always_comb begin
    raw = result_buffer[buf_idx][aprf_pkg::RES_W-1:0];
    if (ctrl_ff.result_format_select) begin
      fmt = {raw, 6'h00};
    end else begin
      fmt = {6'h00, raw};
    end
  end

  always_comb begin
    nxt_rdata = '0;
    nxt_err   = 1'b0;
    case (paddr)
      aprf_pkg::OFS_CTRL: begin
        nxt_rdata[aprf_pkg::CTRL_ON_BIT]   = ctrl_ff.converter_on;
        nxt_rdata[aprf_pkg::CTRL_RESULT_FORMAT_SELECT_BIT] = ctrl_ff.result_format_select;
      end
      aprf_pkg::OFS_PINCFG: begin
        nxt_rdata[NPIN-1:0] = pin_analog_select_ff;
      end
      aprf_pkg::OFS_PINDIR: begin
        nxt_rdata[NPIN-1:0] = pin_direction_ff;
      end
      aprf_pkg::OFS_PORT: begin
        nxt_rdata[NPIN-1:0] = port_ff;
      end
      aprf_pkg::OFS_STATUS: begin
        nxt_rdata[aprf_pkg::STAT_BUSY_BIT] = (state_ff != aprf_pkg::ST_IDLE);
        nxt_rdata[aprf_pkg::STAT_PEND_BIT] = any_pend;
        nxt_rdata[aprf_pkg::STAT_ON_BIT]   = ctrl_ff.converter_on;
      end
      aprf_pkg::OFS_REQ: begin
        nxt_rdata[NPIN-1:0] = pend_ff;
      end
      default: begin
        if (buf_hit) begin
          nxt_rdata[aprf_pkg::BUF_W-1:0] = fmt;
        end else begin
          nxt_err = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // APB handshake: one wait state, pready pulses for one cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= (wr_en | rd_en) & nxt_err;
      if (rd_en) begin
        prdata <= nxt_rdata;
      end
    end
  end

endmodule : aprf_top

`default_nettype wire

//--- aprf_pkg.sv
/*
  Package for the converter power, reset and result-format control block.
  Assumes a 32-bit APB slave on pclk; the top, checker and bench files depend on it.
*/
package aprf_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_PINCFG   = 12'h004;
  localparam logic [11:0] OFS_PINDIR   = 12'h008;
  localparam logic [11:0] OFS_PORT     = 12'h00C;
  localparam logic [11:0] OFS_STATUS   = 12'h010;
  localparam logic [11:0] OFS_REQ      = 12'h014;
  localparam logic [11:0] OFS_BUF_BASE = 12'h040;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          CTRL_ON_BIT     = 0;
  localparam int          CTRL_RESULT_FORMAT_SELECT_BIT   = 1;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_PEND_BIT   = 1;
  localparam int          STAT_ON_BIT     = 2;
  localparam int          RES_W           = 10;
  localparam int          BUF_W           = 16;
  localparam logic [7:0]  PINCFG_RST      = 8'hFF;
  localparam logic [7:0]  PINDIR_RST      = 8'hFF;
  localparam logic [3:0]  CONV_CYCLES     = 4'hC;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMP = 2'b01,
    ST_CONV = 2'b10
  } aprf_state_t;

  typedef struct packed {
    logic converter_on;
    logic result_format_select;
  } aprf_ctrl_t;

endpackage : aprf_pkg

//--- aprf_core_model.sv
/*
  Converter core model: answers each start with a done pulse and a result.
  Assumes the converter control block drives core_start on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module aprf_core_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Converter side
  input  wire logic       core_start,
  output logic            core_done,
  output logic [9:0]      core_data,
  output logic [9:0]      last_data
);
  logic [2:0] wait_ff;
  // Result lines scramble outside the done cycle
  assign core_data = core_done ? last_data : ~last_data;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff   <= 3'h0;
      core_done <= 1'b0;
      last_data <= 10'h000;
    end else if (core_start) begin
      wait_ff   <= 3'(1 + $urandom % 4);
      last_data <= 10'($urandom);
      core_done <= 1'b0;
    end else begin
      core_done <= (wait_ff == 3'h1);
      wait_ff   <= (wait_ff != 3'h0) ? wait_ff - 3'h1 : 3'h0;
    end
  end
endmodule : aprf_core_model
`default_nettype wire

//--- aprf_top_checker.sv
/*
  Port assertions for the converter control block.
  Assumes it is bound into aprf_top.
*/
`timescale 1ns/100ps
`default_nettype none
module aprf_top_checker #(parameter int NPIN = 8) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [NPIN-1:0] pin_dig_in_en,
  input wire logic [NPIN-1:0] pin_to_analog_ground_ref,
  input wire logic [NPIN-1:0] pin_direction_out,
  input wire logic            core_power,
  input wire logic            core_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_power_on: assert property (psel && penable && pready && pwrite &&
    paddr == aprf_pkg::OFS_CTRL && pwdata[0] |-> ##[0:2] core_power)
    else $error("converter not powered after enable");
  a_start_powered: assert property (core_start |-> core_power)
    else $error("conversion started while off");
  a_off_quiet: assert property ($fell(core_power) |-> !core_start [*4])
    else $error("conversion started after power off");
  a_reset_quiet: assert property ($rose(presetn) |-> !core_power &&
    !core_start && !pready && pin_direction_out == '0)
    else $error("outputs active after reset");
  a_analog_ground: assert property (pin_to_analog_ground_ref == pin_dig_in_en)
    else $error("ground tie differs from input enable");
  a_port_zero: assert property (pready && !pwrite && paddr == aprf_pkg::OFS_PORT
    |-> (prdata[NPIN-1:0] & ~pin_dig_in_en) == '0)
    else $error("analog pin reads nonzero");
  a_buf_width: assert property (pready && !pwrite &&
    paddr >= aprf_pkg::OFS_BUF_BASE |-> prdata[31:16] == 16'h0000)
    else $error("result wider than 16 bits");
  a_start_single: assert property (core_start |=> !core_start [*2])
    else $error("start pulse too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : aprf_top_checker
bind aprf_top aprf_top_checker #(.NPIN(NPIN)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_dig_in_en(pin_dig_in_en),
  .pin_to_analog_ground_ref(pin_to_analog_ground_ref),
  .pin_direction_out(pin_direction_out), .core_power(core_power), .core_start(core_start));
`default_nettype wire

//--- tb_adc_power_reset_and_format_ctrl.sv
/*
  Self-checking bench for aprf_top with a converter core model.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_adc_power_reset_and_format_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic core_power, core_start, core_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, seed_v;
  logic [7:0] pin_level, dig_en, gnd, dir_out, m;
  logic [2:0] core_channel;
  logic [9:0] core_data, last_data, b0;
  logic e;
  logic [9:0] cq[$];
  int error_cnt, check_count, cyc;
  aprf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_level(pin_level), .pin_dig_in_en(dig_en),
    .pin_to_analog_ground_ref(gnd), .pin_direction_out(dir_out), .core_power(core_power),
    .core_start(core_start), .core_channel(core_channel), .core_done(core_done),
    .core_data(core_data));
  aprf_core_model u_core (.pclk(pclk), .presetn(presetn), .core_start(core_start),
    .core_done(core_done), .core_data(core_data), .last_data(last_data));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (core_done === 1'b1) cq.push_back(last_data);
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  function automatic logic [31:0] fmt(input logic [9:0] d, input logic f);
    return f ? {16'h0000, d, 6'h00} : {22'h000000, d};
  endfunction : fmt
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task automatic batch(input logic [7:0] mask, input logic f);
    int k;
    int n;
    k = 0;
    n = 0;
    seed_v = $urandom;
    apb(1'b1, aprf_pkg::OFS_PINDIR, {24'h0, seed_v[7:0]});
    apb(1'b1, aprf_pkg::OFS_PINCFG, {24'h0, seed_v[15:8]});
    chk({24'h0, dir_out}, {24'h0, ~seed_v[7:0]});
    apb(1'b1, aprf_pkg::OFS_CTRL, {30'h0, f, 1'b1});
    cq.delete();
    apb(1'b1, aprf_pkg::OFS_REQ, {24'h0, mask});
    do apb(1'b0, aprf_pkg::OFS_STATUS, 32'h0); while (r[1:0] !== 2'b00 && ++n < 60);
    for (int ch = 0; ch < 8; ch++) begin
      if (mask[ch]) begin
        rd(aprf_pkg::OFS_BUF_BASE + 12'(4 * ch), fmt(cq[k], f));
        k++;
      end
    end
    chk(32'(cq.size()), 32'(k));
  endtask : batch
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pin_level, presetn} = '0;
    seed_v = $urandom(18741);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(aprf_pkg::OFS_CTRL, 32'h0);
    rd(aprf_pkg::OFS_PINCFG, 32'hFF);
    rd(aprf_pkg::OFS_PINDIR, 32'hFF);
    chk({24'h0, dir_out}, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      seed_v = $urandom;
      apb(1'b1, aprf_pkg::OFS_PINCFG, {24'h0, seed_v[7:0]});
      pin_level <= seed_v[15:8];
      repeat (6) @(posedge pclk);
      rd(aprf_pkg::OFS_PORT, {24'h0, seed_v[15:8] & seed_v[7:0]});
      chk({24'h0, dig_en}, {24'h0, seed_v[7:0]});
      chk({24'h0, gnd}, {24'h0, seed_v[7:0]});
    end
    apb(1'b1, aprf_pkg::OFS_REQ, 32'hFF);
    rd(aprf_pkg::OFS_REQ, 32'h0);
    apb(1'b1, aprf_pkg::OFS_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    chk({31'h0, core_power}, 32'h1);
    rd(aprf_pkg::OFS_STATUS, 32'h4);
    batch(8'hFF, 1'b0);
    b0 = cq[0];
    m = 8'($urandom);
    batch({m[7:1], 1'b0} | 8'h80, 1'b1);
    apb(1'b1, aprf_pkg::OFS_REQ, 32'hFF);
    apb(1'b1, aprf_pkg::OFS_CTRL, 32'h0);
    rd(aprf_pkg::OFS_REQ, 32'h0);
    rd(aprf_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, aprf_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, aprf_pkg::OFS_REQ, 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(aprf_pkg::OFS_CTRL, 32'h0);
    rd(aprf_pkg::OFS_STATUS, 32'h0);
    rd(aprf_pkg::OFS_BUF_BASE, fmt(b0, 1'b0));
    test_done();
  end
endmodule : tb_adc_power_reset_and_format_ctrl
`default_nettype wire
